// ===== src/serial_eeprom_status_protect.sv
// Purpose: Status register and write protection of a 1024-byte serial EEPROM
// Assumes: Pins are asynchronous to sys_clk and sampled at 100 MHz
// Notes: Array storage and read path are outside; this block arms array writes

`timescale 1ns/100ps

module serial_eeprom_status_protect #(
	parameter int WRITE_CYCLES = serial_eeprom_status_protect_pkg::WRITE_CYCLES // Internal write length
) (
	input wire logic sys_clk, // System clock
	input wire logic reset_n, // Power-on reset, active low
	input wire logic csN, // Chip select pin, active low
	input wire logic sck, // Serial clock pin
	input wire logic si, // Serial data in pin
	input wire logic wpN, // Write-protect pin, active low
	input wire logic [2:0] nvRestore, // Stored {enable, protect high, protect low}
	output logic soData, // Serial data out value
	output logic soOe, // Serial data out enable
	output logic writeBusy, // Internal write running
	output logic arrayWrStart, // One-cycle pulse: program array
	output logic [9:0] arrayWrAddr, // First address of array write
	output logic nvPinEnable, // Nonvolatile pin-protect enable
	output logic [1:0] nvBlockProt // Nonvolatile block-protect bits
);

	localparam int BUSY_W = $clog2(WRITE_CYCLES + 1); // Busy counter width

	// ==========================================================
	// Decoding helpers
	// ==========================================================

	// Array address guarded by the block-protect code
	function automatic logic blockProt(input logic [1:0] bp, input logic [9:0] a);
		logic hit;
		hit = 1'b0;
		unique case (bp)
			2'b00: hit = 1'b0; // Nothing guarded
			2'b01: hit = (a >= serial_eeprom_status_protect_pkg::PROT_QUARTER_BASE);
			2'b10: hit = (a >= serial_eeprom_status_protect_pkg::PROT_HALF_BASE);
			2'b11: hit = 1'b1; // Whole array
		endcase
		return hit;
	endfunction : blockProt

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic csS1, csS2, sckS1, sckS2, siS1, siS2, wpS1, wpS2; // Two-stage samplers
	logic csPrev_r, sckPrev_r; // Edge history of synchronised pins

	// Every pin passes two flops; edge logic reads only the second stage
	always_ff @(posedge sys_clk) begin
		csS1 <= csN;
		csS2 <= csS1;
		sckS1 <= sck;
		sckS2 <= sckS1;
		siS1 <= si;
		siS2 <= siS1;
		wpS1 <= wpN;
		wpS2 <= wpS1;
		csPrev_r <= csS2;
		sckPrev_r <= sckS2;
	end

	logic sckRise, sckFall, csRise, selected, hwProt; // Decoded pin events
	assign selected = ~csS2;
	assign sckRise = selected & sckS2 & ~sckPrev_r; // Input sampled on rising edge
	assign sckFall = selected & ~sckS2 & sckPrev_r; // Output moves after falling edge
	assign csRise = csS2 & ~csPrev_r;
	assign hwProt = ~wpS2 & nvPinEnable;

	// ==========================================================
	// Sequencer and status state
	// ==========================================================
	serial_eeprom_status_protect_pkg::phase_e state_r, state_nxt; // Serial phase
	logic [7:0] shift_r, shift_nxt; // Incoming byte, MSB first
	logic [7:0] cmd_r, cmd_nxt; // Instruction that armed deselect
	logic [2:0] bitCnt_r, bitCnt_nxt; // Bits within current byte
	logic [4:0] byteCnt_r, byteCnt_nxt; // Address or data bytes seen
	logic [15:0] addr_r, addr_nxt; // Array address, upper bits ignored
	logic [2:0] outIdx_r, outIdx_nxt; // Next status bit to shift out
	logic latch_r, latch_nxt; // Write enable latch
	logic [BUSY_W-1:0] busyCnt_r, busyCnt_nxt; // Internal write timer
	logic soData_nxt, soOe_nxt, busy_nxt, wrStart_nxt, pinEn_nxt;
	logic [1:0] bp_nxt;
	logic [9:0] wrAddr_nxt;
	logic [7:0] statusByte; // Live status image
	logic [7:0] byteIn; // Byte completed on this edge

	// Unused positions read zero
	assign statusByte = {nvPinEnable, 3'b000, nvBlockProt, latch_r, writeBusy};
	assign byteIn = {shift_r[6:0], siS2};

	// Next-state logic for the whole serial sequencer
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		cmd_nxt = cmd_r;
		bitCnt_nxt = bitCnt_r;
		byteCnt_nxt = byteCnt_r;
		addr_nxt = addr_r;
		outIdx_nxt = outIdx_r;
		latch_nxt = latch_r;
		busyCnt_nxt = busyCnt_r;
		soData_nxt = soData;
		soOe_nxt = soOe;
		busy_nxt = writeBusy;
		wrStart_nxt = 1'b0;
		wrAddr_nxt = arrayWrAddr;
		pinEn_nxt = nvPinEnable;
		bp_nxt = nvBlockProt;

		// Self-timed write runs to the end whatever the pin does
		if (writeBusy) begin
			if (busyCnt_r == BUSY_W'(WRITE_CYCLES - 1)) begin
				busy_nxt = 1'b0;
				latch_nxt = 1'b0; // Write completed
				busyCnt_nxt = '0;
			end else begin
				busyCnt_nxt = busyCnt_r + BUSY_W'(1);
			end
		end

		// Common bit shifter while selected
		if (sckRise) begin
			shift_nxt = byteIn;
			bitCnt_nxt = bitCnt_r + 3'd1;
		end

		if (csRise) begin
			// Deselect ends every sequence and releases the output
			state_nxt = serial_eeprom_status_protect_pkg::ST_IDLE;
			soOe_nxt = 1'b0;
			if (state_r == serial_eeprom_status_protect_pkg::ST_ARM) begin
				unique case (cmd_r)
					serial_eeprom_status_protect_pkg::SET_LATCH_CMD: latch_nxt = 1'b1;
					serial_eeprom_status_protect_pkg::CLEAR_LATCH_CMD: latch_nxt = 1'b0;
					serial_eeprom_status_protect_pkg::STATUS_WRITE_CMD: begin
						// Status write needs latch and no hardware protection
						if (latch_r && !hwProt) begin
							pinEn_nxt = shift_r[serial_eeprom_status_protect_pkg::PIN_PROTECT_ENABLE_BIT];
							bp_nxt = shift_r[serial_eeprom_status_protect_pkg::BLOCK_PROTECT_HIGH_BIT:
								serial_eeprom_status_protect_pkg::BLOCK_PROTECT_LOW_BIT];
							busy_nxt = 1'b1;
							busyCnt_nxt = '0;
						end
					end
					// Neutral or cancelled code: deselect must not touch stored bits
					default: ;
				endcase
			end else if (state_r == serial_eeprom_status_protect_pkg::ST_DATA) begin
				// Only whole bytes start programming
				if (bitCnt_r == 3'd0 && byteCnt_r != 5'd0 && latch_r && !blockProt(nvBlockProt, addr_r[9:0])) begin
					wrStart_nxt = 1'b1;
					wrAddr_nxt = addr_r[9:0];
					busy_nxt = 1'b1;
					busyCnt_nxt = '0;
				end
			end
		end else begin
			unique case (state_r)
				serial_eeprom_status_protect_pkg::ST_IDLE: begin
					// Select held low wakes the sequencer
					if (selected) begin
						state_nxt = serial_eeprom_status_protect_pkg::ST_CMD;
						bitCnt_nxt = 3'd0;
						byteCnt_nxt = 5'd0;
					end
				end
				serial_eeprom_status_protect_pkg::ST_CMD: begin
					if (sckRise && bitCnt_r == 3'd7) begin
						cmd_nxt = byteIn;
						// While busy only the status read is served
						if (byteIn == serial_eeprom_status_protect_pkg::STATUS_READ_CMD) begin
							state_nxt = serial_eeprom_status_protect_pkg::ST_STAT_OUT;
							outIdx_nxt = 3'd7;
						end else if (writeBusy) begin
							state_nxt = serial_eeprom_status_protect_pkg::ST_ARM;
							cmd_nxt = 8'h00; // Neutral code, deselect does nothing
						end else if (byteIn == serial_eeprom_status_protect_pkg::SET_LATCH_CMD ||
							byteIn == serial_eeprom_status_protect_pkg::CLEAR_LATCH_CMD) begin
							state_nxt = serial_eeprom_status_protect_pkg::ST_ARM;
						end else if (byteIn == serial_eeprom_status_protect_pkg::STATUS_WRITE_CMD) begin
							state_nxt = serial_eeprom_status_protect_pkg::ST_STAT_IN;
						end else if (byteIn == serial_eeprom_status_protect_pkg::ARRAY_WRITE_CMD) begin
							state_nxt = serial_eeprom_status_protect_pkg::ST_ADDR;
						end else begin
							state_nxt = serial_eeprom_status_protect_pkg::ST_ARM;
							cmd_nxt = 8'h00; // Unknown code is ignored
						end
					end
				end
				serial_eeprom_status_protect_pkg::ST_ADDR: begin
					if (sckRise) begin
						addr_nxt = {addr_r[14:0], siS2};
						if (bitCnt_r == 3'd7) begin
							byteCnt_nxt = byteCnt_r + 5'd1;
							if (byteCnt_r == 5'(serial_eeprom_status_protect_pkg::ADDR_BYTES - 1)) begin
								state_nxt = serial_eeprom_status_protect_pkg::ST_DATA;
								byteCnt_nxt = 5'd0;
							end
						end
					end
				end
				serial_eeprom_status_protect_pkg::ST_DATA: begin
					// Count whole data bytes, saturating
					if (sckRise && bitCnt_r == 3'd7 && byteCnt_r != 5'd31) begin
						byteCnt_nxt = byteCnt_r + 5'd1;
					end
				end
				serial_eeprom_status_protect_pkg::ST_STAT_IN: begin
					// New value is held in the shifter until deselect
					if (sckRise && bitCnt_r == 3'd7) begin
						state_nxt = serial_eeprom_status_protect_pkg::ST_ARM;
					end
				end
				serial_eeprom_status_protect_pkg::ST_STAT_OUT: begin
					// Status repeats while clocks continue
					if (sckFall) begin
						soData_nxt = statusByte[outIdx_r];
						soOe_nxt = 1'b1;
						outIdx_nxt = outIdx_r - 3'd1;
					end
				end
				serial_eeprom_status_protect_pkg::ST_ARM: begin
					// Extra clocks spoil the armed action
					if (sckRise) begin
						cmd_nxt = 8'h00;
					end
				end
				default: state_nxt = serial_eeprom_status_protect_pkg::ST_IDLE;
			endcase
		end
	end

	// Register stage; nonvolatile bits reload from storage during reset
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_r <= serial_eeprom_status_protect_pkg::ST_IDLE;
			shift_r <= 8'h00;
			cmd_r <= 8'h00;
			bitCnt_r <= 3'd0;
			byteCnt_r <= 5'd0;
			addr_r <= 16'h0000;
			outIdx_r <= 3'd7;
			latch_r <= serial_eeprom_status_protect_pkg::WRITE_LATCH_RESET;
			busyCnt_r <= '0;
			soData <= 1'b0;
			soOe <= 1'b0;
			writeBusy <= 1'b0;
			arrayWrStart <= 1'b0;
			arrayWrAddr <= 10'h000;
			nvPinEnable <= nvRestore[2]; // Retained across power
			nvBlockProt <= nvRestore[1:0];
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			cmd_r <= cmd_nxt;
			bitCnt_r <= bitCnt_nxt;
			byteCnt_r <= byteCnt_nxt;
			addr_r <= addr_nxt;
			outIdx_r <= outIdx_nxt;
			latch_r <= latch_nxt;
			busyCnt_r <= busyCnt_nxt;
			soData <= soData_nxt;
			soOe <= soOe_nxt;
			writeBusy <= busy_nxt;
			arrayWrStart <= wrStart_nxt;
			arrayWrAddr <= wrAddr_nxt;
			nvPinEnable <= pinEn_nxt;
			nvBlockProt <= bp_nxt;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// Armed set-latch followed by deselect
	sequence armSet;
		csRise && state_r == serial_eeprom_status_protect_pkg::ST_ARM &&
			cmd_r == serial_eeprom_status_protect_pkg::SET_LATCH_CMD;
	endsequence
	sequence latchUp;
		latch_r && !soOe;
	endsequence

	standby_off_a: assert property (state_r == serial_eeprom_status_protect_pkg::ST_IDLE |-> !soOe)
		else $error("Output enabled while deselected");
	latch_power_a: assert property ($rose(reset_n) |-> !latch_r)
		else $error("Latch set after power-up");
	busy_length_a: assert property ($fell(writeBusy) |-> $past(busyCnt_r) == BUSY_W'(WRITE_CYCLES - 1))
		else $error("Internal write length wrong");
	latch_done_a: assert property ($fell(writeBusy) |-> !latch_r)
		else $error("Latch not cleared after write");
	array_guard_a: assert property (arrayWrStart |-> $past(latch_r) && writeBusy &&
		!blockProt(nvBlockProt, arrayWrAddr))
		else $error("Array write started without permission");
	nv_guard_a: assert property (($changed(nvBlockProt) || $changed(nvPinEnable)) |->
		$past(latch_r) && !$past(hwProt) && $past(csRise))
		else $error("Nonvolatile bits changed while refused");
	status_msb_a: assert property ($rose(soOe) |-> soData == $past(nvPinEnable))
		else $error("Status read does not start with enable bit");
	latch_set_a: assert property (armSet |=> latchUp)
		else $error("Set-latch instruction had no effect");
	busy_ignore_a: assert property (writeBusy && state_r == serial_eeprom_status_protect_pkg::ST_CMD
		&& sckRise && bitCnt_r == 3'd7 |=> state_r != serial_eeprom_status_protect_pkg::ST_ADDR)
		else $error("Array access accepted while busy");

endmodule : serial_eeprom_status_protect

// ===== src/serial_eeprom_status_protect_pkg.sv
// Purpose: Shared constants for the serial EEPROM status and protection block
// Assumes: 100 MHz system clock, 1024-byte array, serial bus MSB first
// Notes: Offsets, encodings, reset values and cycle counts live here; the status byte order is also fixed in the block

package serial_eeprom_status_protect_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 10; // System clock period
	localparam int WRITE_TIME_NS = 5000000; // Longest internal write time, 5 ms
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS; // Rounded down

	// ==========================================================
	// Instruction codes
	// ==========================================================
	localparam logic [7:0] SET_LATCH_CMD = 8'h06; // Set write enable latch
	localparam logic [7:0] CLEAR_LATCH_CMD = 8'h04; // Clear write enable latch
	localparam logic [7:0] STATUS_READ_CMD = 8'h05; // Read status byte
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01; // Write status byte
	localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02; // Array byte or page write

	// ==========================================================
	// Status byte layout
	// ==========================================================
	localparam int PIN_PROTECT_ENABLE_BIT = 7; // Enable for the protect pin
	localparam int BLOCK_PROTECT_HIGH_BIT = 3; // Upper block-protect bit
	localparam int BLOCK_PROTECT_LOW_BIT = 2; // Lower block-protect bit
	localparam int WRITE_LATCH_FLAG_BIT = 1; // Write enable latch
	localparam int WRITE_BUSY_FLAG_BIT = 0; // Internal write running
	localparam logic WRITE_LATCH_RESET = 1'b0; // Latch value after power-up

	// ==========================================================
	// Array protection boundaries
	// ==========================================================
	localparam logic [9:0] PROT_QUARTER_BASE = 10'h300; // Upper quarter start
	localparam logic [9:0] PROT_HALF_BASE = 10'h200; // Upper half start
	localparam int ADDR_BYTES = 2; // Address bytes after a write code

	// ==========================================================
	// Serial sequencer states
	// ==========================================================
	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001, // Deselected standby
		ST_CMD = 7'b000_0010, // Receiving instruction byte
		ST_ADDR = 7'b000_0100, // Receiving array address
		ST_DATA = 7'b000_1000, // Receiving array data
		ST_STAT_IN = 7'b001_0000, // Receiving new status byte
		ST_STAT_OUT = 7'b010_0000, // Shifting status out
		ST_ARM = 7'b100_0000 // Waiting for deselect to act
	} phase_e;

endpackage : serial_eeprom_status_protect_pkg

// ===== verification/serial_host_model.sv
// Purpose: Behavioural serial bus host that frames transfers to the block
// Assumes: Half a serial clock period is 8 sys_clk cycles, 160 ns per bit
// Notes: Serial clock idles low and stands still outside frames

`timescale 1ns/100ps

module serial_host_model (
	input wire logic sys_clk, // Pacing clock
	input wire logic soData, // Device serial out value
	input wire logic soOe, // Device serial out enable
	output logic csN, // Chip select, active low
	output logic sck, // Serial clock
	output logic si // Serial data to the device
);
	// ==========================================================
	// Idle levels
	// ==========================================================
	// Deselected with a quiet clock from time zero
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end

	// Wait a number of falling sys_clk edges
	task automatic pause(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : pause

	// ==========================================================
	// Framed transfer
	// ==========================================================
	// Clock nBits of tx out, keep the last 8 bits seen on the output
	task automatic frame(input logic [31:0] tx, input int nBits, output logic [7:0] rx);
		rx = 8'h00;
		pause(1);
		csN = 1'b0; // Falling select starts a frame
		pause(8);
		for (int i = nBits - 1; i >= 0; i--) begin
			si = tx[i]; // Highest bit goes first
			pause(8);
			// Sample before the rise; a released output reads unknown
			rx = {rx[6:0], (soOe === 1'b1) ? soData : 1'bx};
			sck = 1'b1;
			pause(8);
			sck = 1'b0;
		end
		si = ~si; // No stale level once the frame is over
		pause(8);
		csN = 1'b1; // Deselect right after the last bit
		pause(8);
	endtask : frame
endmodule : serial_host_model

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the status and protection block
// Assumes: 100 MHz clock, internal write shortened to 1200 cycles
// Notes: Host model makes all serial traffic; bench owns the other pins

`timescale 1ns/100ps

module tb_top;
	localparam int WR_CYC = 1200; // Shortened write, longer than one frame
	logic sysClk; // System clock
	logic resetN; // Synchronous reset, active low
	logic csN, sck, si, soData, soOe; // Serial link
	logic wpN; // Write-protect pin, active low
	logic [2:0] nvRestore; // Stored status bits
	logic writeBusy, arrayWrStart, nvPinEnable; // Status outputs
	logic [9:0] arrayWrAddr; // Accepted array address
	logic [1:0] nvBlockProt; // Block-protect outputs
	int failures = 0; // Mismatch count
	int cmp_count = 0; // Comparison count
	int startCount = 0; // Array start pulses seen
	logic [7:0] rx; // Last read byte

	// ==========================================================
	// Clock, instances and pulse counter
	// ==========================================================
	initial sysClk = 1'b0;
	always #5 sysClk = ~sysClk;

	serial_eeprom_status_protect #(.WRITE_CYCLES(WR_CYC)) u_serial_eeprom_status_protect (
		.sys_clk(sysClk), .reset_n(resetN), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
		.nvRestore(nvRestore), .soData(soData), .soOe(soOe), .writeBusy(writeBusy),
		.arrayWrStart(arrayWrStart), .arrayWrAddr(arrayWrAddr), .nvPinEnable(nvPinEnable),
		.nvBlockProt(nvBlockProt));

	serial_host_model u_serial_host_model (.sys_clk(sysClk), .soData(soData), .soOe(soOe),
		.csN(csN), .sck(sck), .si(si));

	// Count one-cycle start pulses mid-cycle, where the output has settled
	always @(negedge sysClk) begin
		if (arrayWrStart === 1'b1) begin
			startCount++;
		end
	end

	// ==========================================================
	// Shared tasks
	// ==========================================================
	// Compare a value, four-state exact
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Framed transfer through the host model
	task automatic xfer(input logic [31:0] tx, input int n);
		u_serial_host_model.frame(tx, n, rx);
	endtask : xfer

	// Read the status byte and compare it
	task automatic readStatus(input logic [7:0] exp);
		xfer(32'({serial_eeprom_status_protect_pkg::STATUS_READ_CMD, 8'hA5}), 16);
		check(16'(rx), 16'(exp));
	endtask : readStatus

	// Latch then status write, as a host must
	task automatic wrStatus(input logic [7:0] v);
		xfer(32'(serial_eeprom_status_protect_pkg::SET_LATCH_CMD), 8);
		xfer(32'({serial_eeprom_status_protect_pkg::STATUS_WRITE_CMD, v}), 16);
	endtask : wrStatus

	// Bounded wait for the internal write to finish
	task automatic waitIdle;
		for (int i = 0; i < 3000 && writeBusy !== 1'b0; i++) @(negedge sysClk);
		check(16'(writeBusy), 16'h0000);
	endtask : waitIdle

	// ==========================================================
	// Scenarios
	// ==========================================================
	// Power-up state comes from the stored bits, latch clear, output off
	task automatic t_power;
		check(16'({nvPinEnable, nvBlockProt, soOe, writeBusy}), 16'h000C);
		readStatus(8'h0C);
	endtask : t_power

	// Set and clear latch codes
	task automatic t_latch;
		xfer(32'(serial_eeprom_status_protect_pkg::SET_LATCH_CMD), 8);
		readStatus(8'h0E);
		xfer(32'(serial_eeprom_status_protect_pkg::CLEAR_LATCH_CMD), 8);
		readStatus(8'h0C);
	endtask : t_latch

	// Status write tries to set read-only and unused bits too
	task automatic t_stat_write;
		wrStatus(8'h7B);
		readStatus(8'h0B); // Read while busy
		check(16'(nvBlockProt), 16'h0002);
		waitIdle;
		readStatus(8'h08);
	endtask : t_stat_write

	// Protect pin with its enable, refusal and latch commands under protection
	task automatic t_hw_protect;
		wrStatus(8'h80);
		wpN = 1'b0; // Falls during the running write
		waitIdle;
		check(16'(nvPinEnable), 16'h0001);
		wrStatus(8'h8C);
		check(16'({writeBusy, nvBlockProt}), 16'h0000);
		readStatus(8'h82);
		xfer(32'(serial_eeprom_status_protect_pkg::CLEAR_LATCH_CMD), 8);
		readStatus(8'h80);
		wpN = 1'b1;
		wrStatus(8'h0C);
		waitIdle;
		check(16'({nvPinEnable, nvBlockProt}), 16'h0003);
	endtask : t_hw_protect

	// Every protect code against boundary addresses
	task automatic t_array;
		logic [9:0] addrs[6];
		int n0;
		logic prot;
		addrs = '{10'h000, 10'h1FF, 10'h200, 10'h2FF, 10'h300, 10'h3FF};
		for (int bp = 3; bp >= 0; bp--) begin
			wrStatus(8'(bp << 2));
			waitIdle;
			foreach (addrs[k]) begin
				prot = (bp == 3) || (bp == 2 && addrs[k] >= 10'h200) || (bp == 1 && addrs[k] >= 10'h300);
				xfer(32'(serial_eeprom_status_protect_pkg::SET_LATCH_CMD), 8);
				n0 = startCount;
				xfer({serial_eeprom_status_protect_pkg::ARRAY_WRITE_CMD, 6'h00, addrs[k], 8'h5A}, 32);
				check(16'(startCount - n0), prot ? 16'h0000 : 16'h0001);
				if (!prot) begin
					check(16'(arrayWrAddr), 16'(addrs[k]));
					n0 = startCount;
					xfer({serial_eeprom_status_protect_pkg::ARRAY_WRITE_CMD, 16'h0000, 8'h33}, 32);
					check(16'(startCount - n0), 16'h0000); // Ignored while busy
					waitIdle;
					readStatus(8'(bp << 2));
				end
			end
		end
		n0 = startCount;
		xfer({serial_eeprom_status_protect_pkg::ARRAY_WRITE_CMD, 16'h0000, 8'h11}, 32);
		check(16'(startCount - n0), 16'h0000); // Latch clear blocks all
	endtask : t_array

	// Overlong latch frame and cut array frame arm nothing
	task automatic t_refuse;
		int n0;
		xfer(32'({serial_eeprom_status_protect_pkg::SET_LATCH_CMD, 1'b0}), 9);
		readStatus(8'h00); // Extra clock cancels the set
		xfer(32'(serial_eeprom_status_protect_pkg::SET_LATCH_CMD), 8);
		n0 = startCount;
		xfer(32'({serial_eeprom_status_protect_pkg::ARRAY_WRITE_CMD, 16'h0000, 7'h11}), 31);
		check(16'(startCount - n0), 16'h0000); // Partial byte refused
		readStatus(8'h02); // Latch kept, no write done
		xfer(32'(serial_eeprom_status_protect_pkg::CLEAR_LATCH_CMD), 8);
		readStatus(8'h00);
	endtask : t_refuse

	// ==========================================================
	// Run control
	// ==========================================================
	// Print counts and verdict, then stop
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence, reset held 16 cycles
	initial begin
		resetN = 1'b0;
		wpN = 1'b1;
		nvRestore = 3'b011;
		repeat (16) @(negedge sysClk);
		resetN = 1'b1;
		repeat (4) @(negedge sysClk);
		t_power;
		t_latch;
		t_stat_write;
		t_hw_protect;
		t_array;
		t_refuse;
		report_and_stop;
	end

	// Watchdog well beyond the expected 50k cycles of all scenarios
	initial begin
		repeat (90000) @(posedge sysClk);
		failures++;
		$display("BAD %0t watchdog expired", $time);
		report_and_stop;
	end
endmodule : tb_top
